// >>> hw/rtcirq_top.sv
// interrupt pin, square-wave pin, test mode and stop/prescaler of the rtc
`timescale 1ns/100ps
module rtcirq_top (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  // register access
  input  wire logic                      reg_wr,
  input  wire logic [3:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata_r,
  // events from calendar, countdown timer and alarm; second tick out
  input  wire logic                      minute_inc,
  input  wire logic                      countdown_event,
  input  wire rtcirq_pkg::rtcirq_cdsrc_t countdown_src,
  input  wire logic                      countdown_n_is_one,
  input  wire logic                      alarm_event,
  output logic                           second_tick_r,
  // interrupt pin, open-drain
  output logic                           int_n_out_r,
  output logic                           int_oe_r,
  // square-wave pin, open-drain or test input
  input  wire logic                      square_wave_pin_in,
  output logic                           square_wave_pin_out_r,
  output logic                           square_wave_pin_oe_r
);
  import rtcirq_pkg::*;

  function automatic logic bit_cleared(input logic wr, input logic [7:0] d, input int b);
    bit_cleared = wr && !d[b];
  endfunction

  // registers
  logic [7:0]       ctrl1_r;
  logic [7:0]       ctrl2_r;
  logic [2:0]       square_wave_freq_select_r;
  logic [ACC_W-1:0] acc_r;
  logic             osc_lvl_r;
  logic [PRE_W-1:0] pre_r;
  logic [TST_W-1:0] tst_r;
  logic             pin_s1_r;
  logic             pin_s2_r;
  logic             pin_s3_r;

  // decode
  wire              wr1      = reg_wr && (reg_addr == CTRL1_ADDR);
  wire              wr2      = reg_wr && (reg_addr == CTRL2_ADDR);
  wire              wr_sqw   = reg_wr && (reg_addr == SQW_CTRL_ADDR);
  wire              external_clock_test = ctrl1_r[EXTERNAL_CLOCK_TEST_BIT];
  wire              stop     = ctrl1_r[STOP_BIT];
  wire              minute_irq_enable    = ctrl2_r[MI_BIT];
  wire              second_irq_enable    = ctrl2_r[SI_BIT];
  wire              minsec_flag          = ctrl2_r[MSF_BIT];
  wire              timer_irq_pulse_select = ctrl2_r[TIMER_IRQ_PULSE_SELECT_BIT];
  wire              alarm_flag           = ctrl2_r[AF_BIT];
  wire              countdown_flag       = ctrl2_r[TF_BIT];
  wire              alarm_irq_enable     = ctrl2_r[AIE_BIT];
  wire              countdown_irq_enable = ctrl2_r[TIE_BIT];

  // oscillator emulation: half-period enable from a phase accumulator
  wire [ACC_W:0]    acc_sum  = {1'b0, acc_r} + {1'b0, ACC_STEP};
  wire              half_en  = acc_sum >= {1'b0, ACC_LIMIT};
  wire [ACC_W-1:0]  acc_nxt  = half_en ? ACC_W'(acc_sum - {1'b0, ACC_LIMIT})
                                       : acc_sum[ACC_W-1:0];
  wire              osc_tick = half_en && !osc_lvl_r;

  // normal prescaler; stop clears stages three and up only
  wire [PRE_W-1:0]  pre_inc  = (osc_tick && !external_clock_test) ? pre_r + PRE_W'(1) : pre_r;
  wire [PRE_W-1:0]  pre_nxt  = stop ? {{(PRE_W-PRE_RST_LO){1'b0}}, pre_inc[PRE_RST_LO-1:0]}
                                    : pre_inc;
  wire              sec_norm = !pre_r[PRE_W-1] && pre_nxt[PRE_W-1];

  // test prescaler, clocked by synchronised pin edges
  wire              pin_rise = pin_s2_r && !pin_s3_r;
  wire [TST_W-1:0]  tst_nxt  = stop ? '0
                             : (pin_rise ? tst_r + TST_W'(1) : tst_r);
  wire              sec_test = !tst_r[TST_W-1] && tst_nxt[TST_W-1];
  wire              sec_tick = external_clock_test ? sec_test : sec_norm;

  // minsec and countdown flag sources
  wire              ms_set = second_irq_enable ? sec_tick
                           : (minute_irq_enable && minute_inc);
  wire              cd_set = countdown_event;

  // control 2 next value: flags set by hardware win over a clearing write
  wire [7:0]        ctrl2_wv  = wr2 ? reg_wdata : ctrl2_r;
  wire              msf_nxt   = ms_set || (minsec_flag && !bit_cleared(wr2, reg_wdata, MSF_BIT));
  wire              af_nxt    = alarm_event || (alarm_flag && !bit_cleared(wr2, reg_wdata, AF_BIT));
  wire              tf_nxt    = cd_set || (countdown_flag && !bit_cleared(wr2, reg_wdata, TF_BIT));
  wire [7:0]        ctrl2_nxt = {ctrl2_wv[MI_BIT], ctrl2_wv[SI_BIT], msf_nxt, ctrl2_wv[TIMER_IRQ_PULSE_SELECT_BIT],
                                 af_nxt, tf_nxt, ctrl2_wv[AIE_BIT], ctrl2_wv[TIE_BIT]};

  // pulse generators, both counted on the raw oscillator tick, not the test-gated prescaler input
  rtcirq_pulse_if ms_pif ();
  rtcirq_pulse_if cd_pif ();

  logic [PLS_W-1:0] cd_len;
  always_comb begin
    unique case (countdown_src)
      CD_4096: cd_len = countdown_n_is_one ? PLS_8192 : PLS_4096;
      CD_64:   cd_len = countdown_n_is_one ? PLS_128 : PLS_64;
      CD_1HZ:  cd_len = PLS_64;
      CD_60TH: cd_len = PLS_64;
    endcase
  end

  assign ms_pif.tick  = osc_tick;
  assign ms_pif.len   = PLS_64;
  assign ms_pif.start = ms_set && timer_irq_pulse_select;
  assign ms_pif.kill  = !msf_nxt;
  assign cd_pif.tick  = osc_tick;
  assign cd_pif.len   = cd_len;
  assign cd_pif.start = cd_set && timer_irq_pulse_select && countdown_irq_enable;
  assign cd_pif.kill  = !tf_nxt || !ctrl2_nxt[TIE_BIT];

  rtcirq_pulse u_ms_pulse (
    .mclk (mclk),
    .rstn (rstn),
    .pif  (ms_pif)
  );

  rtcirq_pulse u_cd_pulse (
    .mclk (mclk),
    .rstn (rstn),
    .pif  (cd_pif)
  );

  // interrupt sources
  wire ms_src = timer_irq_pulse_select ? ms_pif.active
                : (minsec_flag && (minute_irq_enable || second_irq_enable));
  wire cd_src = countdown_irq_enable && (timer_irq_pulse_select ? cd_pif.active
                : countdown_flag);
  wire al_src = alarm_irq_enable && alarm_flag;
  wire any_src = ms_src || cd_src || al_src;

  // square-wave level; divider bits give the 50:50 duty
  logic sqw_lvl;
  always_comb begin
    unique case (square_wave_freq_select_r)
      3'h0:    sqw_lvl = osc_lvl_r;
      3'h1:    sqw_lvl = pre_r[0];
      3'h2:    sqw_lvl = pre_r[1];
      3'h3:    sqw_lvl = pre_r[2];
      3'h4:    sqw_lvl = pre_r[3];
      3'h5:    sqw_lvl = pre_r[4];
      3'h6:    sqw_lvl = pre_r[PRE_W-1];
      3'h7:    sqw_lvl = 1'b0;
    endcase
  end
  // stopped upper stages sit at zero, so slow selections already read low under stop
  wire sqw_oe_nxt = !external_clock_test && !sqw_lvl;

  // sequential state
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl1_r                   <= CTRL1_RST;
      ctrl2_r                   <= CTRL2_RST;
      square_wave_freq_select_r <= SQW_SEL_RST;
    end else begin
      ctrl1_r                   <= wr1 ? reg_wdata : ctrl1_r;
      ctrl2_r                   <= ctrl2_nxt;
      square_wave_freq_select_r <= wr_sqw ? reg_wdata[2:0] : square_wave_freq_select_r;
    end
  end

  // tst_r counts pin rises outside test mode too, so entry state is unknown until stop
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      acc_r     <= '0;
      osc_lvl_r <= 1'b0;
      pre_r     <= '0;
      tst_r     <= '0;
    end else begin
      acc_r     <= acc_nxt;
      osc_lvl_r <= osc_lvl_r ^ half_en;
      pre_r     <= pre_nxt;
      tst_r     <= tst_nxt;
    end
  end

  // pin synchroniser; only the second and third stage are looked at
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= square_wave_pin_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // outputs
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_r           <= 8'h00;
      second_tick_r         <= 1'b0;
      int_n_out_r           <= 1'b0;
      int_oe_r              <= 1'b0;
      square_wave_pin_out_r <= 1'b0;
      square_wave_pin_oe_r  <= 1'b1;
    end else begin
      reg_rdata_r           <= (reg_addr == CTRL1_ADDR) ? ctrl1_r
                             : (reg_addr == CTRL2_ADDR) ? ctrl2_r
                             : (reg_addr == SQW_CTRL_ADDR) ? {5'h00, square_wave_freq_select_r}
                             : 8'h00;
      second_tick_r         <= sec_tick;
      int_n_out_r           <= 1'b0;
      int_oe_r              <= any_src;
      square_wave_pin_out_r <= 1'b0;
      square_wave_pin_oe_r  <= sqw_oe_nxt;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  logic [PLS_W:0] ms_len_cnt_r;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) ms_len_cnt_r <= '0;
    else if (!ms_pif.active) ms_len_cnt_r <= '0;
    else if (osc_tick) ms_len_cnt_r <= ms_len_cnt_r + (PLS_W+1)'(1);
  end

  property p_int_or;
    any_src |=> int_oe_r;
  endproperty
  a_int_or: assert property (p_int_or) else $error("int pin not driven");
  property p_int_idle;
    !any_src |=> !int_oe_r;
  endproperty
  a_int_idle: assert property (p_int_idle) else $error("int pin not released");
  property p_ms_len;
    ms_pif.active |-> ms_len_cnt_r <= (PLS_W+1)'(PLS_64);
  endproperty
  a_ms_len: assert property (p_ms_len) else $error("minsec pulse too long");
  property p_ms_kill;
    timer_irq_pulse_select && minsec_flag && bit_cleared(wr2, reg_wdata, MSF_BIT) && !ms_set
      |=> !ms_pif.active ##1 !int_oe_r || cd_src || al_src;
  endproperty
  a_ms_kill: assert property (p_ms_kill) else $error("minsec pulse not ended");
  property p_cd_gate;
    // checked at the pin, so a countdown path around the enable would show
    !countdown_irq_enable && !ms_src && !al_src |=> !int_oe_r;
  endproperty
  a_cd_gate: assert property (p_cd_gate) else $error("countdown leaked to pin");
  property p_alarm;
    alarm_irq_enable && alarm_flag |=> int_oe_r;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm not on pin");
  property p_sqw_off;
    square_wave_freq_select_r == SQW_SEL_OFF && !external_clock_test |=> square_wave_pin_oe_r;
  endproperty
  a_sqw_off: assert property (p_sqw_off) else $error("sqw pin not low");
  property p_stop_low;
    // select must stay slow too: a switch to 8192 Hz under stop runs again
    (stop && !external_clock_test && square_wave_freq_select_r >= SQW_SEL_4096) [*2]
      |=> square_wave_pin_oe_r;
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("slow sqw runs under stop");
  property p_test_in;
    external_clock_test |=> !square_wave_pin_oe_r;
  endproperty
  a_test_in: assert property (p_test_in) else $error("test pin still driven");
  property p_tst_stop;
    stop |=> tst_r == '0;
  endproperty
  a_tst_stop: assert property (p_tst_stop) else $error("test prescaler not cleared");
  property p_pre_stop;
    stop |=> pre_r[PRE_W-1:PRE_RST_LO] == '0 && !second_tick_r;
  endproperty
  a_pre_stop: assert property (p_pre_stop) else $error("prescaler runs under stop");
  property p_msf_never;
    !minute_irq_enable && !second_irq_enable && !minsec_flag |=> !minsec_flag;
  endproperty
  a_msf_never: assert property (p_msf_never) else $error("minsec flag set");

  c_ms_pulse:  cover property (ms_pif.start ##1 ms_pif.active);
  c_cd_pulse:  cover property (cd_pif.start ##1 cd_pif.active);
  c_alarm_int: cover property (al_src ##1 int_oe_r);
  c_test_sec:  cover property (external_clock_test && sec_test);
endmodule

// >>> hw/rtcirq_pkg.sv
// constants and types of the rtc interrupt, square-wave and prescaler block
package rtcirq_pkg;
  // register addresses and bit positions
  localparam logic [3:0] CTRL1_ADDR    = 4'h0;
  localparam logic [3:0] CTRL2_ADDR    = 4'h1;
  localparam logic [3:0] SQW_CTRL_ADDR = 4'hD;
  localparam int         EXTERNAL_CLOCK_TEST_BIT  = 7;
  localparam int         STOP_BIT      = 5;
  localparam int         MI_BIT        = 7;
  localparam int         SI_BIT        = 6;
  localparam int         MSF_BIT       = 5;
  localparam int         TIMER_IRQ_PULSE_SELECT_BIT     = 4;
  localparam int         AF_BIT        = 3;
  localparam int         TF_BIT        = 2;
  localparam int         AIE_BIT       = 1;
  localparam int         TIE_BIT       = 0;
  // reset values and square-wave select codes
  localparam logic [7:0] CTRL1_RST     = 8'h00;
  localparam logic [7:0] CTRL2_RST     = 8'h00;
  localparam logic [2:0] SQW_SEL_RST   = 3'h0;
  localparam logic [2:0] SQW_SEL_OFF   = 3'h7;
  localparam logic [2:0] SQW_SEL_1HZ   = 3'h6;
  localparam logic [2:0] SQW_SEL_4096  = 3'h3;
  // clock and oscillator rates
  localparam int         CLK_HZ        = 100_000_000;
  localparam int         OSC_HZ        = 32_768;
  localparam int         ACC_W         = 27;
  localparam logic [ACC_W-1:0] ACC_STEP  = ACC_W'(2 * OSC_HZ);
  localparam logic [ACC_W-1:0] ACC_LIMIT = ACC_W'(CLK_HZ);
  // prescaler layout
  localparam int         PRE_W         = 15;
  localparam int         PRE_RST_LO    = 2;
  localparam int         PRE_64HZ_BIT  = 8;
  localparam int         TST_W         = 6;
  // interrupt pulse widths in oscillator periods
  localparam int         PLS_W         = 11;
  localparam logic [PLS_W-1:0] PLS_64     = PLS_W'(OSC_HZ / 64);
  localparam logic [PLS_W-1:0] PLS_128    = PLS_W'(OSC_HZ / 128);
  localparam logic [PLS_W-1:0] PLS_4096   = PLS_W'(OSC_HZ / 4096);
  localparam logic [PLS_W-1:0] PLS_8192   = PLS_W'(OSC_HZ / 8192);
  // countdown source clock
  typedef enum logic [1:0] {
    CD_4096 = 2'b00,
    CD_64   = 2'b01,
    CD_1HZ  = 2'b10,
    CD_60TH = 2'b11
  } rtcirq_cdsrc_t;
endpackage

// >>> hw/rtcirq_pulse_if.sv
// carrier between the interrupt logic and a pulse stretcher
`timescale 1ns/100ps
interface rtcirq_pulse_if;
  import rtcirq_pkg::*;
  logic             start;
  logic             kill;
  logic             tick;
  logic [PLS_W-1:0] len;
  logic             active;
  modport gen (input start, input kill, input tick, input len, output active);
  modport ctl (output start, output kill, output tick, output len, input active);
endinterface

// >>> hw/rtcirq_pulse.sv
// interrupt pulse stretcher counted in oscillator periods
`timescale 1ns/100ps
module rtcirq_pulse (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // pulse control
  rtcirq_pulse_if.gen pif
);
  import rtcirq_pkg::*;

  logic [PLS_W-1:0] cnt_r;
  logic             active_r;
  wire              last_tick = active_r && pif.tick && (cnt_r == PLS_W'(1));

  assign pif.active = active_r;

  // kill wins: a cleared flag ends the pulse at once
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r    <= '0;
      active_r <= 1'b0;
    end else if (pif.kill) begin
      active_r <= 1'b0;
    end else if (pif.start) begin
      cnt_r    <= pif.len;
      active_r <= 1'b1;
    end else if (active_r && pif.tick) begin
      cnt_r    <= cnt_r - PLS_W'(1);
      active_r <= !last_tick;
    end
  end
endmodule

// >>> bench/rtcirq_host_model.sv
// host side: pull-ups on both pins and the test clock source
`timescale 1ns/100ps
module rtcirq_host_model (
  // clock
  input  wire logic       mclk,
  // pin drivers from the device
  input  wire logic       int_oe,
  input  wire logic       int_out,
  input  wire logic       sqw_oe,
  input  wire logic       sqw_out,
  // test clock request
  input  wire logic [6:0] n_edges,
  input  wire logic       go,
  output logic            busy,
  // resolved pin levels
  output logic            int_pin,
  output logic            sqw_pin
);
  logic drive;
  logic lvl;
  // released pins float up to the pull-up level, except sqw_pin once the host drives it
  assign int_pin = int_oe ? int_out : 1'b1;
  assign sqw_pin = sqw_oe ? sqw_out : (drive ? lvl : 1'b1);
  // clock held low between bursts; 300 ns high, 1000 ns period
  // levels change by non-blocking assignment so the synchroniser never races them
  initial begin
    drive = 1'b0;
    lvl   = 1'b0;
    busy  = 1'b0;
    forever begin
      @(posedge mclk);
      if (go) begin
        busy  <= 1'b1;
        drive <= 1'b1;
        repeat (n_edges) begin
          repeat (70) @(posedge mclk);
          lvl <= 1'b1;
          repeat (30) @(posedge mclk);
          lvl <= 1'b0;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

// >>> bench/tb_rtcirq_top.sv
// self-checking bench for the rtc interrupt, square-wave and prescaler block
`timescale 1ns/100ps
module tb_rtcirq_top;
  import rtcirq_pkg::*;
  logic          mclk = 1'b0;
  logic          rstn = 1'b0;
  logic          reg_wr = 1'b0;
  logic [3:0]    reg_addr = 4'h0;
  logic [7:0]    reg_wdata = 8'h00;
  logic [7:0]    rdata;
  logic          minute_inc = 1'b0;
  logic          countdown_event = 1'b0;
  rtcirq_cdsrc_t countdown_src = CD_4096;
  logic          n_one = 1'b0;
  logic          alarm_event = 1'b0;
  logic          second_tick;
  logic          int_oe;
  logic          sqw_oe;
  logic          int_out;
  logic          sqw_out;
  logic          int_pin;
  logic          sqw_pin;
  logic          busy;
  logic          go = 1'b0;
  logic [6:0]    n_edges = 7'h00;
  integer        mismatches = 0;
  integer        n_checks = 0;
  integer        seed = 32'h0BCE;
  integer        m2 = 0;
  integer        ticks = 0;
  int            t;
  int            hi;
  int            lo;
  int            wq[$] = '{4, 8};

  always #5 mclk = ~mclk;
  always @(posedge mclk) if (second_tick === 1'b1) ticks <= ticks + 1;

  rtcirq_top u_dut (
    .mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_r(rdata), .minute_inc(minute_inc),
    .countdown_event(countdown_event), .countdown_src(countdown_src),
    .countdown_n_is_one(n_one), .alarm_event(alarm_event), .second_tick_r(second_tick),
    .int_n_out_r(int_out), .int_oe_r(int_oe), .square_wave_pin_in(sqw_pin),
    .square_wave_pin_out_r(sqw_out), .square_wave_pin_oe_r(sqw_oe)
  );
  rtcirq_host_model u_host (
    .mclk(mclk), .int_oe(int_oe), .int_out(int_out), .sqw_oe(sqw_oe),
    .sqw_out(sqw_out), .n_edges(n_edges), .go(go),
    .busy(busy), .int_pin(int_pin), .sqw_pin(sqw_pin)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic rng(input string what, input int v, input int a, input int b);
    chk(what, (v >= a && v <= b) ? a : v, a);
  endtask
  // sample a little after the edge, once the design outputs have settled
  task automatic cyc(inout int n);
    @(posedge mclk);
    #1 n++;
  endtask
  // model: flags are and-ed on write, set by events
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    if (a == CTRL2_ADDR) m2 = (d & 8'hD3) | (m2 & d & 8'h2C);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    repeat (2) @(posedge mclk);
    #1 chk("rdata", rdata, e);
  endtask
  task automatic ev(input int k);
    @(posedge mclk);
    if (k == 0) minute_inc <= 1'b1;
    else if (k == 1) countdown_event <= 1'b1;
    else alarm_event <= 1'b1;
    @(posedge mclk);
    minute_inc <= 1'b0;
    countdown_event <= 1'b0;
    alarm_event <= 1'b0;
    if (k == 0 && m2[7] && !m2[6]) m2 = m2 | 8'h20;
    if (k == 1) m2 = m2 | 8'h04;
    if (k == 2) m2 = m2 | 8'h08;
  endtask
  // level-mode pin expected from the model flags and enables
  task automatic pin();
    logic e;
    e = !((m2[3] & m2[1]) | (!m2[4] & ((m2[2] & m2[0]) | (m2[5] & (m2[7] | m2[6])))));
    repeat (3) @(posedge mclk);
    #1 chk("int pin", int_pin, e);
  endtask
  task automatic meas(output int h, output int l);
    int n;
    n = 0;
    while (sqw_pin !== 1'b0 && n < 30000) cyc(n);
    while (sqw_pin !== 1'b1 && n < 60000) cyc(n);
    h = 0;
    while (sqw_pin === 1'b1 && h < 30000) cyc(h);
    l = 0;
    while (sqw_pin === 1'b0 && l < 30000) cyc(l);
  endtask
  task automatic stay(input int n, output int lows);
    lows = 0;
    repeat (n) begin
      @(posedge mclk);
      #1;
      if (sqw_pin === 1'b0) lows++;
    end
  endtask
  task automatic edges(input int k);
    int n;
    n = 0;
    n_edges <= 7'(k);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (2) @(posedge mclk);
    while (busy === 1'b1 && n < 20000) cyc(n);
    repeat (6) @(posedge mclk);
  endtask

  // run is about 100k cycles; twice that means a hang
  initial begin
    #2_000_000;
    mismatches++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    chk("int pin", int_pin, 1'b1);  // released after reset
    rd(CTRL1_ADDR, CTRL1_RST);  // test mode and stop off after reset
    rd(CTRL2_ADDR, CTRL2_RST);
    rd(SQW_CTRL_ADDR, 8'h00);  // default select
    t = 2 + ($unsigned($random(seed)) % 11);
    rd(t[3:0], 8'h00);  // only the select register holds the field
    meas(hi, lo);
    rng("osc high", hi, 1220, 1832);  // default output runs
    wr(SQW_CTRL_ADDR, 8'h01);
    meas(hi, lo);
    rng("half high", hi, 3049, 3054);  // even duty
    rng("half low", lo, 3049, 3054);  // divided rate
    wr(SQW_CTRL_ADDR, {5'h00, SQW_SEL_OFF});
    stay(4000, t);
    chk("off low", t, 4000);  // held low
    wr(CTRL1_ADDR, 8'h20);
    wr(SQW_CTRL_ADDR, 8'h03);
    stay(13000, t);
    chk("stopped low", t, 13000);  // slow select frozen
    wr(SQW_CTRL_ADDR, 8'h02);
    stay(7000, t);
    chk("runs in stop", t < 7000, 1'b1);  // fast select runs
    wr(CTRL1_ADDR, 8'h00);
    wr(CTRL2_ADDR, 8'h03);
    ev(2);
    pin();  // alarm level
    ev(1);
    pin();  // countdown level follows its flag
    wr(CTRL2_ADDR, 8'h07);
    pin();  // countdown still holds the pin
    rd(CTRL2_ADDR, m2[7:0]);  // only one flag cleared
    wr(CTRL2_ADDR, 8'h03);
    pin();  // cleared flag drops the level
    wr(CTRL2_ADDR, 8'h01);
    countdown_src <= rtcirq_cdsrc_t'(2'($random(seed)));
    ev(1);
    pin();  // enabled countdown reaches the pin
    wr(CTRL2_ADDR, 8'h04);
    pin();  // enable clear drops level
    rd(CTRL2_ADDR, 8'h04);
    ev(1);
    pin();  // disabled countdown kept off pin
    wr(CTRL2_ADDR, 8'h00);
    ev(0);
    rd(CTRL2_ADDR, 8'h00);  // no enables, no flag
    wr(CTRL2_ADDR, 8'h90);
    ev(0);
    repeat (200) @(posedge mclk);
    chk("minute pulse", int_pin, 1'b0);  // well inside 1/64 s
    wr(CTRL2_ADDR, 8'h90);
    repeat (3) @(posedge mclk);
    chk("pulse cut", int_pin, 1'b1);
    countdown_src <= CD_4096;
    wr(CTRL2_ADDR, 8'h11);
    foreach (wq[i]) begin
      n_one <= (wq[i] == 4);
      ev(1);
      t = 0;
      while (int_pin !== 1'b0 && t < 20) cyc(t);
      hi = 0;
      while (int_pin === 1'b0 && hi < 40000) cyc(hi);
      rng("cd pulse", hi, (wq[i] - 1) * 3052, (wq[i] + 1) * 3052);
      rd(CTRL2_ADDR, m2[7:0]);  // flag outlives the pulse
      wr(CTRL2_ADDR, 8'h11);
    end
    ev(1);
    repeat (100) @(posedge mclk);
    wr(CTRL2_ADDR, 8'h11);
    repeat (3) @(posedge mclk);
    chk("cd cut", int_pin, 1'b1);
    wr(CTRL1_ADDR, 8'h80);  // host test entry order
    wr(CTRL1_ADDR, 8'hA0);
    wr(CTRL1_ADDR, 8'h80);
    wr(CTRL2_ADDR, 8'h40);
    t = ticks;
    edges(31);
    chk("sqw released", sqw_oe, 1'b0);  // pin is an input
    chk("tick early", ticks, t);
    edges(1);
    chk("first tick", ticks, t + 1);
    m2 = m2 | 8'h20;
    pin();  // seconds flag drives the pin
    edges(63);
    chk("next tick early", ticks, t + 1);
    edges(1);
    chk("next tick", ticks, t + 2);
    wr(CTRL1_ADDR, 8'hA0);
    edges(10);
    wr(CTRL1_ADDR, 8'h80);
    edges(32);
    chk("tick after stop", ticks, t + 3);  // stop zeroes the count
    wr(CTRL2_ADDR, 8'h20);
    pin();  // both enables off drop level
    conclude();
  end
endmodule
